//--- design/smb_pkg.sv
/*
 * Shared constants and types for the two-wire client port: address
 * table, timing counts, state encoding and the register write word.
 * Assumes a single 125 MHz system clock for every user of the package.
 */
package smb_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ      = 125_000_000;  // System clock rate
   localparam int TOUT_MS     = 30;           // Clock-low inactivity time, ms
   localparam int IDLE_US     = 200;          // Both-lines-high idle time, us
   localparam int SCL_MAX_KHZ = 400;          // Fastest serial clock served
   localparam int TOUT_CYC    = (CLK_HZ / 1000) * TOUT_MS;
   localparam int IDLE_CYC    = (CLK_HZ / 1_000_000) * IDLE_US;
   // Shortest serial clock half period in system cycles (156 at 400 kHz)
   localparam int SCL_HALF_CYC = CLK_HZ / (SCL_MAX_KHZ * 1000 * 2);
   localparam int TO_W        = 22;           // Width of the timeout counter

   // ---------------------------------------------------------------
   // Addresses
   // ---------------------------------------------------------------
   localparam logic [6:0] ARA_ADDR = 7'h0c;   // Alert response address
   localparam logic [3:0] SEL_OPEN = 4'h f;   // Select code of an open input
   localparam int         FIFO_DEPTH = 16;    // Words buffered toward registers

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ACK, ST_WDATA, ST_RDATA, ST_RLOAD, ST_HACK, ST_WAIT
   } smb_state_e;

   typedef struct packed {
      logic [7:0] addr;                       // Register location
      logic [7:0] data;                       // Byte to store there
   } smb_wr_s;

   // Address-select decode: sixteen codes onto sixteen client addresses
   function automatic logic [6:0] smb_addr_of(input logic [3:0] sel);
      logic [6:0] a;
      a = 7'h18;
      unique case (sel)
         4'h0: a = 7'h4c;
         4'h1: a = 7'h4d;
         4'h2: a = 7'h4e;
         4'h3: a = 7'h4f;
         4'h4: a = 7'h48;
         4'h5: a = 7'h49;
         4'h6: a = 7'h4a;
         4'h7: a = 7'h4b;
         4'h8: a = 7'h28;
         4'h9: a = 7'h29;
         4'ha: a = 7'h2a;
         4'hb: a = 7'h2b;
         4'hc: a = 7'h2c;
         4'hd: a = 7'h2d;
         4'he: a = 7'h2e;
         4'hf: a = 7'h18;
      endcase
      return a;
   endfunction : smb_addr_of

endpackage : smb_pkg

//--- design/smb_fifo.sv
/*
 * Small synchronous FIFO with a registered output stage.
 * Assumes both sides run on the same clock; the reader may stall.
 */
`timescale 1ns/100ps
module smb_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   // ---------------------------------------------------------------
   // Storage and pointers
   // ---------------------------------------------------------------
   logic [WIDTH-1:0] mem [DEPTH];          // Word store
   logic [AW-1:0]    wptr, next_wptr;      // Write position
   logic [AW-1:0]    rptr, next_rptr;      // Read position
   logic [AW:0]      fill, next_fill;      // Words held in the store
   logic             next_ovalid;          // Output stage full next
   logic [WIDTH-1:0] next_odata;           // Output stage word next
   logic             do_wr, do_rd;         // Store accesses this cycle

   // Full is honest: the store refuses once all DEPTH words are held
   assign in_ready = (fill != (AW+1)'(DEPTH));

   // Next values of pointers, fill and output stage
   always_comb begin
      do_wr       = in_valid && in_ready;
      do_rd       = (fill != '0) && (!out_valid || out_ready);
      next_wptr   = do_wr ? wptr + 1'b1 : wptr;
      next_rptr   = do_rd ? rptr + 1'b1 : rptr;
      next_fill   = fill + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      next_ovalid = out_valid;
      next_odata  = out_data;
      if (do_rd) begin
         // Refill the output register from the store
         next_ovalid = 1'b1;
         next_odata  = mem[rptr];
      end else if (out_ready) begin
         next_ovalid = 1'b0;
      end
   end

   // Register everything; the store itself has no reset
   always_ff @(posedge clock) begin
      if (do_wr) begin
         mem[wptr] <= in_data;
      end
      if (rst) begin
         wptr      <= '0;
         rptr      <= '0;
         fill      <= '0;
         out_valid <= 1'b0;
         out_data  <= '0;
      end else begin
         wptr      <= next_wptr;
         rptr      <= next_rptr;
         fill      <= next_fill;
         out_valid <= next_ovalid;
         out_data  <= next_odata;
      end
   end

endmodule : smb_fifo

//--- design/smb_client.sv
/*
 * Two-wire client port: start/stop detection, address match, byte
 * shifting with acknowledge, register pointer, alert response and the
 * optional timeouts. Register writes leave through a FIFO.
 * Assumes rd_data follows rd_addr on the same clock within a few cycles,
 * and that the serial lines arrive unsynchronised from the pins.
 */
`timescale 1ns/100ps

module smb_client #(
   parameter int TOUT_CYC = smb_pkg::TOUT_CYC,   // Clock-low timeout cycles
   parameter int IDLE_CYC = smb_pkg::IDLE_CYC    // Idle timeout cycles
) (
   input  wire logic           clock,
   input  wire logic           rst,
   input  wire logic           serial_clock_pin,
   input  wire logic           sda_in,
   output logic                sda_out,
   output logic                sda_oe,
   input  wire logic [3:0]     addr_sel,
   input  wire logic           timeout_en,
   input  wire logic           alert_active,
   output logic                alert_mask_set,
   output logic [7:0]          rd_addr,
   input  wire logic [7:0]     rd_data,
   output logic                wr_valid,
   input  wire logic           wr_ready,
   output smb_pkg::smb_wr_s    wr_word
);

   // ---------------------------------------------------------------
   // Line synchronisers and edge detection
   // ---------------------------------------------------------------
   logic scl_m, sda_m;          // First stage, read only by second stage
   logic scl_s, sda_s;          // Synchronised levels
   logic scl_d, sda_d;          // One cycle older, for edges

   // Two flops per line; the third gives the previous level
   always_ff @(posedge clock) begin
      if (rst) begin
         {scl_m, sda_m, scl_s, sda_s, scl_d, sda_d} <= 6'h3f;
      end else begin
         scl_m <= serial_clock_pin;
         sda_m <= sda_in;
         scl_s <= scl_m;
         sda_s <= sda_m;
         scl_d <= scl_s;
         sda_d <= sda_s;
      end
   end

   logic scl_rise, scl_fall, start_det, stop_det;
   // Sampling on our own 8 ns clock leaves >150 cycles per half period
   assign scl_rise  = scl_s && !scl_d;
   assign scl_fall  = !scl_s && scl_d;
   assign start_det = scl_s && scl_d && sda_d && !sda_s;
   assign stop_det  = scl_s && scl_d && !sda_d && sda_s;

   // ---------------------------------------------------------------
   // Inactivity and idle timeouts
   // ---------------------------------------------------------------
   smb_pkg::smb_state_e      state, next_state;    // Protocol phase
   logic [smb_pkg::TO_W-1:0] to_cnt, next_to_cnt;  // Cycles since a line moved
   logic                     timeout_hit;          // Interface reset request

   // Count while both lines hold still; saturate at the top
   always_comb begin
      if ((scl_s != scl_d) || (sda_s != sda_d)) begin
         next_to_cnt = '0;
      end else if (&to_cnt) begin
         next_to_cnt = to_cnt;
      end else begin
         next_to_cnt = to_cnt + 1'b1;
      end
      // Both samples must agree, so a freshly reached level never inherits
      // the count of the previous one; with timeout_en set, a clock low held TOUT_CYC cycles trips the reset
      timeout_hit = timeout_en && (state != smb_pkg::ST_IDLE) &&
                    ((!scl_s && !scl_d && to_cnt >= smb_pkg::TO_W'(TOUT_CYC)) ||
                     (scl_s && sda_s && scl_d && sda_d &&
                      to_cnt > smb_pkg::TO_W'(IDLE_CYC)));
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         to_cnt <= '0;
      end else begin
         to_cnt <= next_to_cnt;
      end
   end

   // ---------------------------------------------------------------
   // Protocol state machine
   // ---------------------------------------------------------------
   logic [3:0] cnt, next_cnt;                // Bit position in the byte
   logic [7:0] shreg, next_shreg;            // Shift register both ways
   logic       drive, next_drive;            // Pulling data low
   logic       rw, next_rw;                  // Host reads
   logic       is_ara, next_ara;             // Answering alert response
   logic       first_wr, next_first;         // Next written byte is pointer
   logic       ack_armed, next_armed;        // Acknowledge clock under way
   logic [7:0] ptr, next_ptr;                // Register pointer
   logic       next_mask;                    // Alert mask pulse
   logic       push, next_push;              // FIFO write strobe
   smb_pkg::smb_wr_s wdata, next_wdata;      // FIFO write word
   logic [7:0] rx_byte;                      // Byte as completed this edge
   logic [7:0] tx_byte;                      // Byte to be sent next
   logic [6:0] own_addr;                     // Selected client address
   logic       fifo_ready;                   // Room for another write

   assign own_addr = smb_pkg::smb_addr_of(addr_sel);
   // An alert response returns our address; otherwise the pointed register
   assign tx_byte  = is_ara ? {own_addr, 1'b0} : rd_data;

   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      next_shreg = shreg;
      next_drive = drive;
      next_rw    = rw;
      next_ara   = is_ara;
      next_first = first_wr;
      next_armed = ack_armed;
      next_ptr   = ptr;
      next_mask  = 1'b0;
      next_push  = 1'b0;
      next_wdata = wdata;
      rx_byte    = {shreg[6:0], sda_s};
      if (stop_det || timeout_hit) begin
         // Stop or timeout: release the line, wait for a new start
         next_state = smb_pkg::ST_IDLE;
         next_drive = 1'b0;
      end else if (start_det) begin
         // Start or repeated start: always begin with an address
         next_state = smb_pkg::ST_ADDR;
         next_cnt   = '0;
         next_drive = 1'b0;
      end else begin
         unique case (state)
            smb_pkg::ST_IDLE, smb_pkg::ST_WAIT: begin
               // Ignore the bus until the next start
            end
            smb_pkg::ST_ADDR: begin
               if (scl_rise) begin
                  next_shreg = rx_byte;
                  next_cnt   = cnt + 4'h1;
                  if (cnt == 4'h7) begin
                     next_cnt   = '0;
                     next_armed = 1'b0;
                     if (rx_byte[7:1] == own_addr) begin
                        next_rw    = rx_byte[0];
                        next_ara   = 1'b0;
                        next_first = !rx_byte[0];
                        next_state = smb_pkg::ST_ACK;
                     end else if (rx_byte[7:1] == smb_pkg::ARA_ADDR &&
                                  rx_byte[0] && alert_active) begin
                        next_rw    = 1'b1;
                        next_ara   = 1'b1;
                        next_state = smb_pkg::ST_ACK;
                     end else begin
                        next_state = smb_pkg::ST_WAIT;
                     end
                  end
               end
            end
            smb_pkg::ST_ACK: begin
               if (scl_fall && !ack_armed) begin
                  // Pull low for the whole ninth clock
                  next_drive = 1'b1;
                  next_armed = 1'b1;
               end else if (scl_fall) begin
                  next_drive = 1'b0;
                  next_armed = 1'b0;
                  next_cnt   = '0;
                  if (rw) begin
                     next_shreg = {tx_byte[6:0], 1'b0};
                     next_drive = !tx_byte[7];
                     next_cnt   = 4'h1;
                     next_state = smb_pkg::ST_RDATA;
                  end else begin
                     next_state = smb_pkg::ST_WDATA;
                  end
               end
            end
            smb_pkg::ST_WDATA: begin
               if (scl_rise) begin
                  next_shreg = rx_byte;
                  next_cnt   = cnt + 4'h1;
                  if (cnt == 4'h7) begin
                     next_cnt = '0;
                     if (first_wr) begin
                        next_ptr   = rx_byte;
                        next_first = 1'b0;
                        next_state = smb_pkg::ST_ACK;
                     end else if (fifo_ready) begin
                        // Bytes while the buffer has room, each to the next register
                        next_push  = 1'b1;
                        next_wdata = '{addr: ptr, data: rx_byte};
                        next_ptr   = ptr + 8'h01;
                        next_state = smb_pkg::ST_ACK;
                     end else begin
                        // No room: leave the byte unacknowledged
                        next_state = smb_pkg::ST_WAIT;
                     end
                  end
               end
            end
            smb_pkg::ST_RLOAD: begin
               if (scl_fall) begin
                  next_shreg = {tx_byte[6:0], 1'b0};
                  next_drive = !tx_byte[7];
                  next_cnt   = 4'h1;
                  next_state = smb_pkg::ST_RDATA;
               end
            end
            smb_pkg::ST_RDATA: begin
               if (scl_rise && !drive && !sda_s) begin
                  // Lost the line to another sender: stop sending
                  next_state = smb_pkg::ST_WAIT;
               end else if (scl_fall && cnt == 4'h8) begin
                  next_drive = 1'b0;
                  next_state = smb_pkg::ST_HACK;
               end else if (scl_fall) begin
                  next_drive = !shreg[7];
                  next_shreg = {shreg[6:0], 1'b0};
                  next_cnt   = cnt + 4'h1;
               end
            end
            smb_pkg::ST_HACK: begin
               if (scl_rise) begin
                  if (is_ara) begin
                     // Whole address went out: mask the alert
                     next_mask  = 1'b1;
                     next_state = smb_pkg::ST_WAIT;
                  end else begin
                     next_ptr   = ptr + 8'h01;
                     // High data in the ninth clock ends the read
                     next_state = sda_s ? smb_pkg::ST_WAIT : smb_pkg::ST_RLOAD;
                  end
               end
            end
         endcase
      end
   end

   // Register the protocol state
   always_ff @(posedge clock) begin
      if (rst) begin
         state          <= smb_pkg::ST_IDLE;
         cnt            <= '0;
         shreg          <= '0;
         drive          <= 1'b0;
         rw             <= 1'b0;
         is_ara         <= 1'b0;
         first_wr       <= 1'b0;
         ack_armed      <= 1'b0;
         ptr            <= '0;
         alert_mask_set <= 1'b0;
         push           <= 1'b0;
         wdata          <= '0;
      end else begin
         state          <= next_state;
         cnt            <= next_cnt;
         shreg          <= next_shreg;
         drive          <= next_drive;
         rw             <= next_rw;
         is_ara         <= next_ara;
         first_wr       <= next_first;
         ack_armed      <= next_armed;
         ptr            <= next_ptr;
         alert_mask_set <= next_mask;
         push           <= next_push;
         wdata          <= next_wdata;
      end
   end

   // ---------------------------------------------------------------
   // Outputs and write buffer
   // ---------------------------------------------------------------
   // Open drain: only ever pull low; the clock line is never driven
   assign sda_out = 1'b0;
   assign sda_oe  = drive;
   assign rd_addr = ptr;

   // Bytes wait here until the register file takes them
   smb_fifo #(
      .WIDTH ($bits(smb_pkg::smb_wr_s)),
      .DEPTH (smb_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_valid  (push),
      .in_ready  (fifo_ready),
      .in_data   (wdata),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (wr_word)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_ack_begin;
      state == smb_pkg::ST_ACK && scl_fall && !ack_armed;
   endsequence
   sequence s_addr_done;
      state == smb_pkg::ST_ADDR && scl_rise && cnt == 4'h7 && !start_det && !stop_det;
   endsequence

   chk_start_seen: assert property (start_det && !stop_det && !timeout_hit |=>
      state == smb_pkg::ST_ADDR && cnt == 4'h0 && !sda_oe)
      else $error("start not taken");
   chk_stop_idle: assert property (stop_det |=>
      state == smb_pkg::ST_IDLE && !sda_oe)
      else $error("stop did not reset client");
   chk_foreign_addr: assert property (s_addr_done and
      ({shreg[6:0], sda_s} != {own_addr, 1'b0}) and ({shreg[6:0], sda_s} != {own_addr, 1'b1})
      and !alert_active |=> state == smb_pkg::ST_WAIT)
      else $error("foreign address answered");
   chk_ack_low: assert property (s_ack_begin and !timeout_hit |=> sda_oe)
      else $error("acknowledge not driven");
   chk_scl_low_change: assert property ($rose(sda_oe) |-> !scl_s)
      else $error("data pulled low while clock high");
   chk_ptr_load: assert property (state == smb_pkg::ST_WDATA && scl_rise &&
      cnt == 4'h7 && first_wr && !start_det && !stop_det && !timeout_hit
      |=> ptr == $past(rx_byte))
      else $error("pointer not loaded");
   chk_ptr_step: assert property (push |-> ptr == $past(ptr) + 8'h01)
      else $error("pointer not advanced");
   chk_mask_cause: assert property (alert_mask_set |->
      is_ara && state == smb_pkg::ST_WAIT)
      else $error("mask set outside alert response");
   chk_idle_reset: assert property (timeout_en && scl_s && sda_s && scl_d &&
      sda_d && to_cnt > smb_pkg::TO_W'(IDLE_CYC) && state != smb_pkg::ST_IDLE
      |=> state == smb_pkg::ST_IDLE)
      else $error("idle timeout missed");
   chk_msb_first: assert property (state == smb_pkg::ST_RLOAD && scl_fall &&
      !start_det && !stop_det && !timeout_hit |=> sda_oe == !$past(tx_byte[7]))
      else $error("first bit not MSB");

endmodule : smb_client

//--- verification/smb_host.sv
/*
 * Behavioural host controller for the two-wire client port.
 * Assumes the bench resolves the open-drain data wire with a pull-up.
 */
`timescale 1ns/100ps
module smb_host (
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   // ------------------------------------------------------------
   // Bus phases; a 160 ns clock period keeps well above 10 kHz
   // ------------------------------------------------------------
   initial begin
      scl = 1'b1;       // Clock stands high between frames
      sda_low = 1'b0;   // Data released, pull-up wins
   end
   // Data falls while clock high; also serves as repeated start
   task automatic start();
      #20 sda_low = 1'b0;
      #60 scl = 1'b1;
      #80 sda_low = 1'b1;
      #80 scl = 1'b0;
   endtask : start
   // Byte out MSB first, data moved only while clock low
   task automatic wbyte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         #20 sda_low = ~b[i];
         #60 scl = 1'b1;
         #80 scl = 1'b0;
      end
      #20 sda_low = 1'b0;
      #60 scl = 1'b1;
      ack = ~sda;
      #80 scl = 1'b0;
   endtask : wbyte
   // Byte in, then acknowledge or refuse it
   task automatic rbyte(input logic nack, output logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         #80 scl = 1'b1;
         b[i] = sda;
         #80 scl = 1'b0;
      end
      #20 sda_low = ~nack;
      #60 scl = 1'b1;
      #80 scl = 1'b0;
      #20 sda_low = 1'b0;
   endtask : rbyte
   // Clock raised and held high with data released, then lowered
   task automatic hold_high(input int ns);
      #80 scl = 1'b1;
      #(ns) scl = 1'b0;
   endtask : hold_high
   // Data rises while clock high
   task automatic stop();
      #20 sda_low = 1'b1;
      #60 scl = 1'b1;
      #80 sda_low = 1'b0;
      #80;
   endtask : stop
endmodule : smb_host

//--- verification/smb_client_tb.sv
/*
 * Self-checking bench for the client port with a host model.
 * Assumes short timeout counts; register contents are a bench pattern.
 */
`timescale 1ns/100ps
module smb_client_tb;
   logic             clock, rst, timeout_en, alert_active, wr_ready, drain;
   logic             scl, sda_low, ack, sda_out, sda_oe, alert_mask_set, wr_valid;
   logic [3:0]       addr_sel;
   logic [7:0]       rd_data, rd_addr, b, p;
   logic [6:0]       own;      // Expected own address
   wire logic        sda;      // Resolved data wire
   smb_pkg::smb_wr_s wr_word;
   logic [15:0]      exp_q[$], got_q[$];
   int               fail_count, n_checks, n_mask;

   assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;  // Pull-up when released
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   smb_client #(.TOUT_CYC(200), .IDLE_CYC(100)) dut (.clock, .rst,
      .serial_clock_pin(scl), .sda_in(sda), .sda_out, .sda_oe, .addr_sel,
      .timeout_en, .alert_active, .alert_mask_set, .rd_addr, .rd_data,
      .wr_valid, .wr_ready, .wr_word);
   smb_host host (.scl, .sda_low, .sda);

   // Register pattern, random consumer stalls, word and pulse capture
   always @(posedge clock) begin
      rd_data <= rd_addr ^ 8'ha5;
      wr_ready <= drain & 1'($urandom_range(1));
      if (wr_valid && wr_ready) got_q.push_back(wr_word);
      if (alert_mask_set) n_mask++;
   end
   // Address decode as the bench expects it
   function automatic logic [6:0] own_of(input logic [3:0] s);
      if (s == 4'hf) return 7'h18;
      if (s[3]) return 7'h28 + {4'h0, s[2:0]};
      return 7'h48 + {4'h0, s[2:0] ^ 3'h4};
   endfunction : own_of
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run();
      if (fail_count == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : complete_run
   // Pointer load without data
   task automatic set_ptr(input logic [7:0] v);
      host.start();
      host.wbyte({own, 1'b0}, ack);
      host.wbyte(v, ack);
      host.stop();
   endtask : set_ptr
   // Hang guard, far beyond the expected run
   initial begin
      #400_000;
      fail_count++;
      complete_run();
   end

   initial begin
      void'($urandom(36));
      {rst, timeout_en, alert_active, drain} = 4'h8;
      addr_sel = 4'h0;
      @(posedge clock) addr_sel <= 4'($urandom_range(15));
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      repeat (10) @(posedge clock);
      own = own_of(addr_sel);
      // Block write that overruns the buffer, consumer stalled
      p = 8'($urandom);
      host.start();
      host.wbyte({own, 1'b0}, ack);
      check(ack, 1);
      host.wbyte(p, ack);
      for (int i = 0; i < 18; i++) begin
         b = 8'($urandom);
         host.wbyte(b, ack);
         check(ack, i < 17);
         if (i < 17) exp_q.push_back({p + 8'(i), b});
      end
      host.stop();
      @(posedge clock) drain <= 1'b1;
      for (int k = 0; k < 800 && got_q.size() < 17; k++) @(posedge clock);
      check(16'(got_q.size()), 17);
      foreach (exp_q[k]) check(got_q[k], exp_q[k]);
      // Foreign address is ignored
      host.start();
      host.wbyte({own ^ 7'h01, 1'b0}, ack);
      check(ack, 0);
      host.stop();
      // Read from a loaded pointer, then successor
      p = 8'($urandom);
      set_ptr(p);
      host.start();
      host.wbyte({own, 1'b1}, ack);
      host.rbyte(1'b0, b);
      check(b, p ^ 8'ha5);
      host.rbyte(1'b1, b);
      check(b, (p + 8'h01) ^ 8'ha5);
      host.stop();
      // Alert response with alert up, then down
      @(posedge clock) alert_active <= 1'b1;
      host.start();
      host.wbyte({smb_pkg::ARA_ADDR, 1'b1}, ack);
      check(ack, 1);
      host.rbyte(1'b1, b);
      check(b, {own, 1'b0});
      host.stop();
      check(16'(n_mask), 1);
      @(posedge clock) alert_active <= 1'b0;
      host.start();
      host.wbyte({smb_pkg::ARA_ADDR, 1'b1}, ack);
      check(ack, 0);
      host.stop();
      // Clock held low mid-read with timeout on: port lets go
      set_ptr({1'b1, 7'($urandom)});
      @(posedge clock) timeout_en <= 1'b1;
      host.start();
      host.wbyte({own, 1'b1}, ack);
      repeat (10) @(posedge clock);
      check(sda_oe, 1);
      repeat (220) @(posedge clock);
      check(sda_oe, 0);
      host.stop();
      // Both lines held high mid-read with timeout on: next bit never driven
      set_ptr({2'b00, 6'($urandom)});
      host.start();
      host.wbyte({own, 1'b1}, ack);
      host.hold_high(1200);
      repeat (10) @(posedge clock);
      check(sda_oe, 0);
      host.stop();
      complete_run();
   end
endmodule : smb_client_tb
